// ### design/nv_sram_host.sv
// Host controller driving a nonvolatile SRAM over its asynchronous pins
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`timescale 1ns/10ps
`include "nv_host_params.svh"

module nv_sram_host (
    // Clock, reset and enable
    input  wire logic                   ref_clk_in,
    input  wire logic                   reset_in,
    input  wire logic                   clk_en_in,
    // Command port
    input  wire logic                   cmd_valid_in,
    input  wire nv_host_pkg::cmd_t      cmd_in,
    input  wire logic [`ADDR_W-1:0]     cmd_addr_in,
    input  wire logic [`DATA_W-1:0]     cmd_wdata_in,
    output logic                        cmd_ready_out,
    output logic                        rsp_valid_out,
    output logic [`DATA_W-1:0]          rsp_rdata_out,
    // Supply status flag only, no mode pins
    input  wire logic                   below_switch_in,
    // Device pins
    output logic [`ADDR_W-1:0]          address_lines_out,
    input  wire logic [`DATA_W-1:0]     data_lines_in,
    output logic [`DATA_W-1:0]          data_lines_out,
    output logic                        data_lines_oe_out,
    output logic                        chip_select_n_out,
    output logic                        write_strobe_n_out,
    output logic                        output_gate_n_out,
    input  wire logic                   store_busy_n_in,
    output logic                        store_busy_n_out,
    output logic                        store_busy_n_oe_out
);

    // ------------------------------------------------------------------------
    // Sequence address lookup
    // ------------------------------------------------------------------------
    // Address of step n; last step picks store or recall
    function automatic logic [`ADDR_W-1:0] seq_addr(input logic [2:0] step,
                                                    input logic recall);
        case (step)
            3'h0:    seq_addr = `SEQ_A0;
            3'h1:    seq_addr = `SEQ_A1;
            3'h2:    seq_addr = `SEQ_A2;
            3'h3:    seq_addr = `SEQ_A3;
            3'h4:    seq_addr = `SEQ_A4;
            default: seq_addr = recall ? `SEQ_RECALL : `SEQ_STORE;
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        nv_host_pkg::state_t st;            // Controller state
        nv_host_pkg::cmd_t   cmd;           // Command in progress
        logic [2:0]          step;          // Sequence step
        logic [`ADDR_W-1:0]  addr;          // Address driven
        logic [`DATA_W-1:0]  wdata;         // Write data driven
        logic [`DATA_W-1:0]  rdata;         // Captured read data
        logic                rsp;           // Response pulse
        logic                cs_n;          // Chip select
        logic                we_n;          // Write strobe
        logic                oe_n;          // Output gate
        logic                dq_oe;         // Data drive enable
        logic                busy_drive;    // Host pulls busy low
    } host_state_t;

    host_state_t cur;                       // Registered state
    host_state_t next_cur;                  // Next value

    logic                timer_load;        // Start timer
    logic [`CNT_W-1:0]   timer_count;       // Timer load value
    logic                timer_done;        // Timer expired
    logic                dev_busy;          // Device reports busy

    assign dev_busy = !store_busy_n_in;

    // ------------------------------------------------------------------------
    // Timer instance
    // ------------------------------------------------------------------------
    bus_cycle_timer u_timer (
        .ref_clk_in (ref_clk_in),
        .reset_in   (reset_in),
        .clk_en_in  (clk_en_in),
        .load_in    (timer_load),
        .count_in   (timer_count),
        .done_out   (timer_done)
    );

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    always_comb begin
        next_cur    = cur;
        next_cur.rsp = 1'b0;
        timer_load  = 1'b0;
        timer_count = `CNT_W'(`STROBE_CYCLES);
        case (cur.st)
            // Accept a command only when device idle and busy high
            nv_host_pkg::ST_IDLE: begin
                if (cmd_valid_in && !dev_busy) begin
                    next_cur.cmd   = cmd_in;
                    next_cur.addr  = cmd_addr_in;
                    next_cur.wdata = cmd_wdata_in;
                    next_cur.step  = 3'h0;
                    case (cmd_in)
                        nv_host_pkg::CMD_SW_STORE,
                        nv_host_pkg::CMD_SW_RECALL: begin
                            next_cur.addr = seq_addr(3'h0, 1'b0);
                            next_cur.st   = nv_host_pkg::ST_SETUP;
                        end
                        nv_host_pkg::CMD_HW_STORE,
                        nv_host_pkg::CMD_WRITE: begin
                            // Refused under low supply
                            if (below_switch_in) begin
                                next_cur.rsp = 1'b1;
                            end else if (cmd_in == nv_host_pkg::CMD_WRITE) begin
                                next_cur.st = nv_host_pkg::ST_SETUP;
                            end else begin
                                next_cur.busy_drive = 1'b1;
                                next_cur.st = nv_host_pkg::ST_BUSY_REQ;
                            end
                        end
                        default: next_cur.st = nv_host_pkg::ST_SETUP;
                    endcase
                end
            end
            // Address settles before any strobe; gate high on writes
            nv_host_pkg::ST_SETUP: begin
                next_cur.cs_n = 1'b0;
                if (cur.cmd == nv_host_pkg::CMD_WRITE) begin
                    next_cur.oe_n  = 1'b1;
                    next_cur.dq_oe = 1'b1;
                    next_cur.we_n  = 1'b0;
                end else begin
                    next_cur.we_n = 1'b1;
                    next_cur.oe_n = 1'b0;
                end
                timer_load  = 1'b1;
                next_cur.st = nv_host_pkg::ST_STROBE;
            end
            // Hold strobes for the access time
            nv_host_pkg::ST_STROBE: begin
                if (timer_done) begin
                    next_cur.rdata = data_lines_in;
                    next_cur.cs_n  = 1'b1;
                    next_cur.we_n  = 1'b1;
                    next_cur.oe_n  = 1'b1;
                    next_cur.st    = nv_host_pkg::ST_RELEASE;
                end
            end
            // Strobes up; address and data still held
            nv_host_pkg::ST_RELEASE: begin
                next_cur.dq_oe = 1'b0;
                if (cur.cmd == nv_host_pkg::CMD_SW_STORE ||
                    cur.cmd == nv_host_pkg::CMD_SW_RECALL) begin
                    next_cur.st = nv_host_pkg::ST_SEQ_NEXT;
                end else begin
                    next_cur.rsp = 1'b1;
                    next_cur.st  = nv_host_pkg::ST_IDLE;
                end
            end
            // Advance the six-read sequence back to back
            nv_host_pkg::ST_SEQ_NEXT: begin
                if (cur.step == 3'h5) begin
                    timer_load  = 1'b1;
                    timer_count = (cur.cmd == nv_host_pkg::CMD_SW_STORE) ?
                                  `CNT_W'(`STORE_CYCLES) :
                                  `CNT_W'(`RECALL_CYCLES);
                    next_cur.st = nv_host_pkg::ST_NV_WAIT;
                end else begin
                    next_cur.step = cur.step + 3'h1;
                    next_cur.addr = seq_addr(cur.step + 3'h1,
                                    cur.cmd == nv_host_pkg::CMD_SW_RECALL);
                    next_cur.st   = nv_host_pkg::ST_SETUP;
                end
            end
            // Device busy with nonvolatile cycle; no accesses
            nv_host_pkg::ST_NV_WAIT: begin
                if (timer_done && !dev_busy) begin
                    next_cur.rsp = 1'b1;
                    next_cur.st  = nv_host_pkg::ST_IDLE;
                end
            end
            // Hold busy low briefly so the device sees the request
            nv_host_pkg::ST_BUSY_REQ: begin
                timer_load  = 1'b1;
                timer_count = `CNT_W'(`BUSY_WAIT_CYCLES);
                next_cur.st = nv_host_pkg::ST_BUSY_WAIT;
            end
            // Release after request time, then wait store end
            nv_host_pkg::ST_BUSY_WAIT: begin
                if (timer_done) begin
                    next_cur.busy_drive = 1'b0;
                    next_cur.st = nv_host_pkg::ST_BUSY_END;
                end
            end
            // Done once busy reads high
            nv_host_pkg::ST_BUSY_END: begin
                if (!dev_busy) begin
                    next_cur.rsp = 1'b1;
                    next_cur.st  = nv_host_pkg::ST_IDLE;
                end
            end
            default: next_cur.st = nv_host_pkg::ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            cur      <= '0;
            cur.cs_n <= 1'b1;
            cur.we_n <= 1'b1;
            cur.oe_n <= 1'b1;
        end else if (clk_en_in) begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign cmd_ready_out       = (cur.st == nv_host_pkg::ST_IDLE) && !dev_busy;
    assign rsp_valid_out       = cur.rsp;
    assign rsp_rdata_out       = cur.rdata;
    assign address_lines_out   = cur.addr;
    assign data_lines_out      = cur.wdata;
    assign data_lines_oe_out   = cur.dq_oe;
    assign chip_select_n_out   = cur.cs_n;
    assign write_strobe_n_out  = cur.we_n;
    assign output_gate_n_out   = cur.oe_n;
    assign store_busy_n_out    = 1'b0;      // Open drain: only pulls low
    assign store_busy_n_oe_out = cur.busy_drive;

endmodule

// ### design/nv_host_params.svh
// Address, timing and sequence constants for the nonvolatile SRAM host controller
`ifndef NV_HOST_PARAMS_SVH
`define NV_HOST_PARAMS_SVH

// ----------------------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------------------
`define ADDR_W            13
`define DATA_W            8

// ----------------------------------------------------------------------------
// Software sequence addresses
// ----------------------------------------------------------------------------
`define SEQ_A0            13'h0000
`define SEQ_A1            13'h1555
`define SEQ_A2            13'h0AAA
`define SEQ_A3            13'h1FFF
`define SEQ_A4            13'h10F0
`define SEQ_STORE         13'h0F0F
`define SEQ_RECALL        13'h0F0E

// ----------------------------------------------------------------------------
// Timing: figures in ns, counts derived from the 25 ns clock
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS     25
`define STORE_TIME_NS     10000000
`define STORE_CYCLES      ((`STORE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECALL_TIME_NS    20000
`define RECALL_CYCLES     ((`RECALL_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STROBE_TIME_NS    100
`define STROBE_CYCLES     ((`STROBE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BUSY_WAIT_NS      1000
`define BUSY_WAIT_CYCLES  ((`BUSY_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CNT_W             20

`endif

// ### design/nv_host_pkg.sv
// Types shared by the nonvolatile SRAM host controller
package nv_host_pkg;

    // ------------------------------------------------------------------------
    // Host command codes
    // ------------------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_READ,
        CMD_WRITE,
        CMD_SW_STORE,
        CMD_SW_RECALL,
        CMD_HW_STORE
    } cmd_t;

    // ------------------------------------------------------------------------
    // Controller states
    // ------------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_RELEASE,
        ST_SEQ_NEXT,
        ST_NV_WAIT,
        ST_BUSY_REQ,
        ST_BUSY_WAIT,
        ST_BUSY_END
    } state_t;

endpackage

// ### design/bus_cycle_timer.sv
// Cycle down-counter used to time strobes and nonvolatile cycles
`timescale 1ns/10ps
`include "nv_host_params.svh"

module bus_cycle_timer (
    // Clock, reset and enable
    input  wire logic                ref_clk_in,
    input  wire logic                reset_in,
    input  wire logic                clk_en_in,
    // Load request with count
    input  wire logic                load_in,
    input  wire logic [`CNT_W-1:0]   count_in,
    // Expiry flag
    output logic                     done_out
);

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [`CNT_W-1:0] remain;   // Cycles still to run
    } timer_state_t;

    timer_state_t cur;               // Registered state
    timer_state_t next_cur;          // Next value

    // Load, count down, hold at zero
    always_comb begin
        next_cur = cur;
        if (load_in) begin
            next_cur.remain = count_in;
        end else if (cur.remain != '0) begin
            next_cur.remain = cur.remain - 1'b1;
        end
    end

    // Register with clock enable
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            cur <= '0;
        end else if (clk_en_in) begin
            cur <= next_cur;
        end
    end

    // Zero means expired
    assign done_out = (cur.remain == '0) && !load_in;

endmodule

// ### tb/nv_sram_host_properties.sv
// Port checks for the nonvolatile SRAM host controller
`timescale 1ns/10ps
`include "nv_host_params.svh"

module nv_sram_host_checker (
    // Clock, reset and enable
    input wire logic                 ref_clk_in,
    input wire logic                 reset_in,
    input wire logic                 clk_en_in,
    // Command port
    input wire logic                 cmd_valid_in,
    input wire nv_host_pkg::cmd_t    cmd_in,
    input wire logic [`ADDR_W-1:0]   cmd_addr_in,
    input wire logic [`DATA_W-1:0]   cmd_wdata_in,
    input wire logic                 cmd_ready_out,
    input wire logic                 rsp_valid_out,
    input wire logic [`DATA_W-1:0]   rsp_rdata_out,
    input wire logic                 below_switch_in,
    // Device pins
    input wire logic [`ADDR_W-1:0]   address_lines_out,
    input wire logic [`DATA_W-1:0]   data_lines_in,
    input wire logic [`DATA_W-1:0]   data_lines_out,
    input wire logic                 data_lines_oe_out,
    input wire logic                 chip_select_n_out,
    input wire logic                 write_strobe_n_out,
    input wire logic                 output_gate_n_out,
    input wire logic                 store_busy_n_in,
    input wire logic                 store_busy_n_out,
    input wire logic                 store_busy_n_oe_out
);
    // ------------------------------------------------------------------------
    // Assertions, one clock domain
    // ------------------------------------------------------------------------
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    a_write_gate_high: assert property (
        !write_strobe_n_out |-> output_gate_n_out && !chip_select_n_out)
        else $error("gate low or select high during write");
    a_write_data_on: assert property (
        !write_strobe_n_out |-> data_lines_oe_out) else $error("write without data drive");
    a_addr_stable: assert property (
        !chip_select_n_out && $past(!chip_select_n_out) |-> $stable(address_lines_out))
        else $error("address moved inside access");
    a_read_strobe_len: assert property (
        $fell(output_gate_n_out) |-> !output_gate_n_out[*3] ##[1:6] output_gate_n_out)
        else $error("read strobe length wrong");
    a_write_strobe_len: assert property (
        $fell(write_strobe_n_out) |-> !write_strobe_n_out[*3] ##[1:6] write_strobe_n_out)
        else $error("write strobe length wrong");
    a_refuse_low_supply: assert property (
        cmd_valid_in && cmd_ready_out && clk_en_in && below_switch_in
        && cmd_in == nv_host_pkg::CMD_WRITE |-> ##1 write_strobe_n_out[*4])
        else $error("write issued under low supply");
    a_busy_no_ready: assert property (
        !store_busy_n_in |-> !cmd_ready_out) else $error("ready while busy low");
    a_pull_low_only: assert property (
        store_busy_n_oe_out |-> !store_busy_n_out) else $error("busy pin driven high");
    a_pull_bounded: assert property (
        $rose(store_busy_n_oe_out) |-> ##[1:100] !store_busy_n_oe_out)
        else $error("busy pin never released");
endmodule

bind nv_sram_host nv_sram_host_checker u_chk (.ref_clk_in, .reset_in, .clk_en_in,
    .cmd_valid_in, .cmd_in, .cmd_addr_in, .cmd_wdata_in, .cmd_ready_out, .rsp_valid_out,
    .rsp_rdata_out, .below_switch_in, .address_lines_out, .data_lines_in, .data_lines_out,
    .data_lines_oe_out, .chip_select_n_out, .write_strobe_n_out, .output_gate_n_out,
    .store_busy_n_in, .store_busy_n_out, .store_busy_n_oe_out);

// ### tb/nv_sram_model.sv
// Behavioural model of the nonvolatile SRAM seen at its pins
`timescale 1ns/10ps
`include "nv_host_params.svh"

module nv_sram_model #(
    parameter int STORE_CYC  = 300,
    parameter int RECALL_CYC = 40,
    parameter int DELAY_CYC  = 4
) (
    // Bench clock for timing
    input wire logic                 clk_in,
    // Pins from the host
    input wire logic [`ADDR_W-1:0]   addr_in,
    input wire logic                 cs_n_in,
    input wire logic                 we_n_in,
    input wire logic                 oe_n_in,
    input wire logic [`DATA_W-1:0]   dq_in,
    input wire logic                 busy_n_in,
    input wire logic                 below_switch_in,
    // Pins to the host and event counts
    output logic [`DATA_W-1:0]       dq_out,
    output logic                     dq_oe_out,
    output logic                     busy_pull_out,
    output int                       store_cnt_out,
    output int                       recall_cnt_out
);
    // ------------------------------------------------------------------------
    // Arrays and state
    // ------------------------------------------------------------------------
    localparam logic [12:0] SEQ [0:4] = '{`SEQ_A0, `SEQ_A1, `SEQ_A2, `SEQ_A3, `SEQ_A4};
    logic [7:0]  sram [0:8191];             // Byte per address
    logic [7:0]  nv [0:8191];               // Shadow array
    logic [12:0] wa, ra;                    // Latched access addresses
    logic [7:0]  wd;                        // Latched write data
    logic        dirty, prev_wr, prev_rd, hw_seen, wr, rd;
    int          seq, busy_cnt, req_cnt, i;

    initial begin
        {dirty, prev_wr, prev_rd, hw_seen, busy_pull_out} = '0;
        {seq, busy_cnt, req_cnt, store_cnt_out, recall_cnt_out} = '0;
        for (i = 0; i < 8192; i++) {sram[i], nv[i]} = 16'h0000;
    end

    // Data out only on a read, off while writing or busy
    assign dq_oe_out = !cs_n_in && !oe_n_in && we_n_in && busy_n_in && busy_cnt == 0;
    assign dq_out = sram[addr_in];

    // Erase and program the shadow, pull busy meanwhile
    task automatic do_store();
        for (i = 0; i < 8192; i++) nv[i] = sram[i];
        dirty = 1'b0;
        store_cnt_out++;
        busy_cnt = STORE_CYC;
        busy_pull_out = 1'b1;
    endtask

    // ------------------------------------------------------------------------
    // Pin activity, acted on just after each edge
    // ------------------------------------------------------------------------
    always begin
        @(posedge clk_in);
        #1;
        wr = !cs_n_in && !we_n_in;
        rd = !cs_n_in && we_n_in;
        if (busy_cnt > 0) begin
            busy_cnt--;
            if (busy_cnt == 0) busy_pull_out = 1'b0;
        end else begin
            if (wr) {wa, wd} = {addr_in, dq_in};
            if (rd) ra = addr_in;
            if (prev_wr && !wr && busy_n_in && !below_switch_in) begin
                sram[wa] = wd;
                dirty = 1'b1;
                seq = 0;
            end else if (prev_rd && !rd) begin
                if (seq == 5 && ra == `SEQ_STORE) begin
                    do_store();
                    seq = 0;
                end else if (seq == 5 && ra == `SEQ_RECALL) begin
                    for (i = 0; i < 8192; i++) sram[i] = nv[i];
                    dirty = 1'b0;
                    recall_cnt_out++;
                    busy_cnt = RECALL_CYC;
                    seq = 0;
                end else begin
                    seq = (seq < 5 && ra == SEQ[seq]) ? seq + 1 : int'(ra == `SEQ_A0);
                end
            end
            if (busy_n_in) begin
                hw_seen = 1'b0;
                req_cnt = 0;
            end else if (!hw_seen) begin
                req_cnt++;
                if (req_cnt == DELAY_CYC) begin
                    hw_seen = 1'b1;
                    if (dirty && !below_switch_in) do_store();
                end
            end
        end
        prev_wr = wr;
        prev_rd = rd;
    end
endmodule

// ### tb/nv_sram_host_tb_top.sv
// Self-checking bench for the nonvolatile SRAM host controller
`timescale 1ns/10ps
`include "nv_host_params.svh"

module nv_sram_host_tb_top;
    // ------------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------------
    logic                ref_clk_in = 1'b0, reset_in = 1'b1, clk_en_in = 1'b1;
    logic                cmd_valid_in = 1'b0, below_switch_in = 1'b0;
    nv_host_pkg::cmd_t   cmd_in = nv_host_pkg::CMD_READ;
    logic [12:0]         cmd_addr_in = 13'h0000;
    logic [7:0]          cmd_wdata_in = 8'h00, rsp_rdata_out, data_lines_in, data_lines_out;
    logic [7:0]          dev_dq, last_dq = 8'h00;
    logic [12:0]         address_lines_out;
    logic                cmd_ready_out, rsp_valid_out, data_lines_oe_out, chip_select_n_out;
    logic                write_strobe_n_out, output_gate_n_out, store_busy_n_in;
    logic                store_busy_n_out, store_busy_n_oe_out, dev_oe, dev_pull;
    int                  store_cnt, recall_cnt, error_cnt = 0, comparisons = 0, s, n;
    localparam logic [12:0] WA [0:3] = '{13'h0000, 13'h1FFF, 13'h0010, 13'h0AAA};
    localparam logic [7:0]  WD [0:3] = '{8'h5A, 8'hC3, 8'h3C, 8'h96};

    always #12.5 ref_clk_in = ~ref_clk_in;

    // Open-drain busy with pull-up; undriven data flips each cycle
    assign store_busy_n_in = !(store_busy_n_oe_out || dev_pull);
    assign data_lines_in = data_lines_oe_out ? data_lines_out : dev_oe ? dev_dq : ~last_dq;
    always @(posedge ref_clk_in) last_dq <= data_lines_in;

    nv_sram_host u_dut (.ref_clk_in, .reset_in, .clk_en_in, .cmd_valid_in, .cmd_in,
        .cmd_addr_in, .cmd_wdata_in, .cmd_ready_out, .rsp_valid_out, .rsp_rdata_out,
        .below_switch_in, .address_lines_out, .data_lines_in, .data_lines_out,
        .data_lines_oe_out, .chip_select_n_out, .write_strobe_n_out, .output_gate_n_out,
        .store_busy_n_in, .store_busy_n_out, .store_busy_n_oe_out);

    nv_sram_model u_mem (.clk_in(ref_clk_in), .addr_in(address_lines_out),
        .cs_n_in(chip_select_n_out), .we_n_in(write_strobe_n_out),
        .oe_n_in(output_gate_n_out), .dq_in(data_lines_in), .busy_n_in(store_busy_n_in),
        .below_switch_in(below_switch_in), .dq_out(dev_dq), .dq_oe_out(dev_oe),
        .busy_pull_out(dev_pull), .store_cnt_out(store_cnt), .recall_cnt_out(recall_cnt));

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic stop_test();
        if (error_cnt == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s: got %h expected %h", $time, m, got, exp);
        end
    endtask

    // Step until flag high; an exhausted bound is a mismatch
    task automatic wait_hi(ref logic f, input int lim, input string m);
        for (n = 0; f !== 1'b1; n++) begin
            if (n >= lim) begin
                chk(1'b0, 1'b1, m);
                stop_test();
            end
            @(posedge ref_clk_in);
            #1;
        end
    endtask

    // One command; lim 0 skips the wait for the answer
    task automatic do_cmd(input nv_host_pkg::cmd_t c, input logic [12:0] a,
                          input logic [7:0] d, input int lim);
        wait_hi(cmd_ready_out, 2000, "ready timeout");
        cmd_valid_in = 1'b1;
        cmd_in = c;
        cmd_addr_in = a;
        cmd_wdata_in = d;
        @(posedge ref_clk_in);
        #1;
        cmd_valid_in = 1'b0;
        if (lim > 0) wait_hi(rsp_valid_out, lim, "answer timeout");
        @(posedge ref_clk_in) #1;
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_write_read();
        for (int i = 0; i < 4; i++) do_cmd(nv_host_pkg::CMD_WRITE, WA[i], WD[i], 50);
        for (int i = 0; i < 4; i++) begin
            do_cmd(nv_host_pkg::CMD_READ, WA[i], 8'h00, 50);
            chk(rsp_rdata_out, WD[i], "read back");
        end
    endtask

    task automatic t_low_supply();
        below_switch_in = 1'b1;
        do_cmd(nv_host_pkg::CMD_WRITE, 13'h0010, 8'hA5, 50);
        below_switch_in = 1'b0;
        do_cmd(nv_host_pkg::CMD_READ, 13'h0010, 8'h00, 50);
        chk(rsp_rdata_out, 8'h3C, "low supply write landed");
    endtask

    task automatic t_hw_store();
        s = store_cnt;
        do_cmd(nv_host_pkg::CMD_HW_STORE, 13'h0000, 8'h00, 2000);
        chk(8'(store_cnt - s), 8'h01, "pin store count");
        do_cmd(nv_host_pkg::CMD_HW_STORE, 13'h0000, 8'h00, 2000);
        chk(8'(store_cnt - s), 8'h01, "clean pin store ran");
    endtask

    task automatic t_sw_recall();
        do_cmd(nv_host_pkg::CMD_WRITE, 13'h0010, 8'h77, 50);
        s = recall_cnt;
        do_cmd(nv_host_pkg::CMD_SW_RECALL, 13'h0000, 8'h00, 2000);
        chk(8'(recall_cnt - s), 8'h01, "recall count");
        do_cmd(nv_host_pkg::CMD_READ, 13'h0010, 8'h00, 50);
        chk(rsp_rdata_out, 8'h3C, "recalled byte");
    endtask

    // Store with no write since recall; reset cuts the long host wait short
    task automatic t_sw_store();
        s = store_cnt;
        do_cmd(nv_host_pkg::CMD_SW_STORE, 13'h0000, 8'h00, 0);
        for (n = 0; n < 2000 && store_cnt == s; n++) @(posedge ref_clk_in);
        chk(8'(store_cnt - s), 8'h01, "sequence store count");
        wait_hi(store_busy_n_in, 2000, "busy stuck");
        reset_in = 1'b1;
        repeat (2) @(posedge ref_clk_in);
        #1;
        reset_in = 1'b0;
        do_cmd(nv_host_pkg::CMD_READ, 13'h1FFF, 8'h00, 50);
        chk(rsp_rdata_out, 8'hC3, "read after store");
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk_in);
        #1;
        reset_in = 1'b0;
        t_write_read();
        t_low_supply();
        t_hw_store();
        t_sw_recall();
        t_sw_store();
        stop_test();
    end
endmodule
